// file: pkg/diw_pkg.sv
// constants for the display image window register group
// assumes one core clock; register indices are word indices on the bus
package diw_pkg;

    // register indices, byte address is four times the index
    localparam logic [7:0] DIW_IDX_VSYNC_WIDTH  = 8'h1F;
    localparam logic [7:0] DIW_IDX_BASE_B0      = 8'h20;
    localparam logic [7:0] DIW_IDX_BASE_B1      = 8'h21;
    localparam logic [7:0] DIW_IDX_BASE_B2      = 8'h22;
    localparam logic [7:0] DIW_IDX_BASE_B3      = 8'h23;
    localparam logic [7:0] DIW_IDX_SPAN_LO      = 8'h24;
    localparam logic [7:0] DIW_IDX_SPAN_HI      = 8'h25;
    localparam logic [7:0] DIW_IDX_LEFT_LO      = 8'h26;
    localparam logic [7:0] DIW_IDX_LEFT_HI      = 8'h27;
    localparam logic [7:0] DIW_IDX_TOP_LO       = 8'h28;
    localparam logic [7:0] DIW_IDX_TOP_HI       = 8'h29;
    localparam logic [7:0] DIW_IDX_INSET_LO     = 8'h2A;
    localparam logic [7:0] DIW_IDX_INSET_SELECT = 8'h40;
    localparam logic [7:0] DIW_IDX_STATUS       = 8'h41;

    // field layouts
    localparam logic [7:0] DIW_MASK_VSYNC = 8'h3F;
    localparam logic [7:0] DIW_MASK_QUAD  = 8'hFC;
    localparam logic [7:0] DIW_MASK_HI5   = 8'h1F;
    localparam logic [7:0] DIW_MASK_SEL   = 8'h01;
    localparam int         DIW_VSYNC_W    = 6;
    localparam int         DIW_COORD_W    = 13;
    localparam int         DIW_HW_W       = 12;

    // status bit positions
    localparam int DIW_ST_LEFT_OVER  = 0;
    localparam int DIW_ST_INSET_OVER = 1;
    localparam int DIW_ST_VSYNC      = 2;
    localparam int DIW_ST_SELECT     = 3;

    // limits and reset values
    localparam logic [13:0] DIW_MAX_SPAN   = 14'h1FFC;
    localparam logic [2:0]  DIW_COARSE_STP = 3'h3;
    localparam logic [7:0]  DIW_RST_BYTE   = 8'h00;

endpackage : diw_pkg

// file: pkg/diw_vs_if.sv
// carrier between the register group and the vsync pulse generator
// assumes both ends run on the same core clock
`timescale 1ns/1ns
interface diw_vs_if;
    logic [5:0] width;
    logic       line_tick;
    logic       frame_start;
    logic       vsync;

    modport regs  (output width, output line_tick, output frame_start, input vsync);
    modport pulse (input width, input line_tick, input frame_start, output vsync);
endinterface : diw_vs_if

// file: hdl/diw_vsync.sv
// vsync pulse generator, width counted in display lines
// assumes line and frame strobes are one-cycle pulses on the core clock
`timescale 1ns/1ns
module diw_vsync
    import diw_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rstn,
    diw_vs_if.pulse   vs
);
    typedef struct packed {
        logic                   active;
        logic [DIW_VSYNC_W-1:0] count;
        logic [DIW_VSYNC_W-1:0] width;
    } diw_vs_s;

    diw_vs_s st_q;
    diw_vs_s st_d;

    always_comb begin
        st_d = st_q;
        // RULE_01 width plus one
        if (vs.frame_start) begin
            // width is latched so a rewrite mid-pulse cannot shorten it
            st_d.active = 1'b1;
            st_d.count  = '0;
            st_d.width  = vs.width;
        end else if (st_q.active && vs.line_tick) begin
            if (st_q.count == st_q.width) begin
                st_d.active = 1'b0;
            end else begin
                st_d.count = st_q.count + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign vs.vsync = st_q.active;
endmodule : diw_vsync

// file: hdl/diw_regs.sv
// display image window register group with wishbone classic slave
// assumes a single core clock, synchronous active-low reset, and
// line/frame strobes and horizontal timing fields from same-clock logic
//
// Notes on behaviour
// RULE_01: vsync pulse lasts programmed six-bit width plus one display lines.
// RULE_02: multi-byte settings take effect only when their top byte is written.
// RULE_03: image base is 32-bit byte address, low two bits always zero.
// RULE_04: image span is 13-bit pixel count, low two bits zero, max 8188.
// RULE_05: main window left is 13-bit pixel position, low two bits zero.
// RULE_06: host keeps main window left plus display width within 8188.
// RULE_07: main window top is 13-bit position, any value 0 to 8191.
// RULE_08: inset window left is relative to main window, low two bits zero.
// RULE_09: host keeps inset window left below the display width.
// RULE_10: inset position writes go to the window picked by select bit.
// RULE_11: display width equals coarse plus one, times eight, plus fine.
// RULE_12: lower bytes wait in shadow until the top byte moves them together.
// RULE_13: reserved bits ignore writes and read back as zero.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ns
module diw_regs
    import diw_pkg::*;
#(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 32
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_rstn,
    // wishbone classic slave
    input  wire logic                   i_wb_cyc,
    input  wire logic                   i_wb_stb,
    input  wire logic                   i_wb_we,
    input  wire logic [ADDR_W-1:0]      i_wb_adr,
    input  wire logic [DATA_W/8-1:0]    i_wb_sel,
    input  wire logic [DATA_W-1:0]      i_wb_dat,
    output logic      [DATA_W-1:0]      o_wb_dat,
    output logic                        o_wb_ack,
    // horizontal timing fields kept by the neighbouring register group
    input  wire logic [7:0]             i_h_active_coarse,
    input  wire logic [3:0]             i_h_active_fine,
    // inset window left top byte, kept by the neighbouring register group
    input  wire logic                   i_inset_left_hi_wr,
    input  wire logic [4:0]             i_inset_left_hi,
    // display timing strobes
    input  wire logic                   i_line_tick,
    input  wire logic                   i_frame_start,
    // active settings
    output logic                        o_vsync,
    output logic [31:0]                 o_main_image_base,
    output logic [DIW_COORD_W-1:0]      o_main_image_span,
    output logic [DIW_COORD_W-1:0]      o_main_view_left,
    output logic [DIW_COORD_W-1:0]      o_main_view_top,
    output logic [DIW_COORD_W-1:0]      o_inset_view_left_1,
    output logic [DIW_COORD_W-1:0]      o_inset_view_left_2,
    output logic [DIW_HW_W-1:0]         o_h_active_width
);
    localparam int IDX_W = ADDR_W - 2;

    if (ADDR_W < 9) begin : g_chk_addr
        $error("diw_regs: ADDR_W must reach the highest register index");
    end
    if (DATA_W != 32) begin : g_chk_data
        $error("diw_regs: only a 32-bit data bus is served");
    end

    typedef struct packed {
        // bus answer
        logic                   ack;
        logic [7:0]             rdat;
        // single-byte settings
        logic [DIW_VSYNC_W-1:0] vsync_width;
        logic                   inset_select;
        // staged bytes, as software last wrote them
        logic [7:0]             base_b0;
        logic [7:0]             base_b1;
        logic [7:0]             base_b2;
        logic [7:0]             base_b3;
        logic [7:0]             span_lo;
        logic [4:0]             span_hi;
        logic [7:0]             left_lo;
        logic [4:0]             left_hi;
        logic [7:0]             top_lo;
        logic [4:0]             top_hi;
        logic [7:0]             inset_lo_1;
        logic [7:0]             inset_lo_2;
        // active settings
        logic [31:0]            base;
        logic [DIW_COORD_W-1:0] span;
        logic [DIW_COORD_W-1:0] left;
        logic [DIW_COORD_W-1:0] top;
        logic [DIW_COORD_W-1:0] inset_1;
        logic [DIW_COORD_W-1:0] inset_2;
        // derived state
        logic [DIW_HW_W-1:0]    h_width;
        logic                   left_over;
        logic                   inset_over;
    } diw_regs_s;

    diw_regs_s st_q;
    diw_regs_s st_d;

    diw_vs_if vs_link ();

    logic [IDX_W-1:0] idx;
    logic [7:0]       wbyte;
    logic             wr_en;
    logic             rd_phase;
    logic [13:0]      left_sum;
    logic [DIW_COORD_W-1:0] inset_sel_q;

    assign idx   = i_wb_adr[ADDR_W-1:2];
    assign wbyte = i_wb_dat[7:0];
    // the write lands on the edge where the master sees ack high
    assign wr_en = i_wb_cyc && i_wb_stb && i_wb_we && st_q.ack && i_wb_sel[0];
    assign rd_phase = i_wb_cyc && i_wb_stb && !st_q.ack;

    // RULE_06 flagged, host must avoid
    assign left_sum = {1'b0, st_q.left} + {2'b00, st_q.h_width};
    assign inset_sel_q = st_q.inset_select ? st_q.inset_2 : st_q.inset_1;

    always_comb begin
        st_d = st_q;

        // one wait state: ack rises the cycle after the request and drops after
        st_d.ack  = i_wb_cyc && i_wb_stb && !st_q.ack;
        st_d.rdat = 8'h00;

        // RULE_11 display width
        st_d.h_width = DIW_HW_W'(({4'h0, i_h_active_coarse} + 12'h001) << DIW_COARSE_STP)
                     + {8'h00, i_h_active_fine};

        st_d.left_over  = left_sum > DIW_MAX_SPAN;
        // RULE_09 flagged for the inset window picked by the select bit only, host must avoid
        st_d.inset_over = {1'b0, inset_sel_q} >= {2'b00, st_q.h_width};

        if (rd_phase) begin
            // RULE_13 reserved reads zero
            unique case (idx)
                IDX_W'(DIW_IDX_VSYNC_WIDTH):  st_d.rdat = {2'b00, st_q.vsync_width};
                IDX_W'(DIW_IDX_BASE_B0):      st_d.rdat = st_q.base_b0;
                IDX_W'(DIW_IDX_BASE_B1):      st_d.rdat = st_q.base_b1;
                IDX_W'(DIW_IDX_BASE_B2):      st_d.rdat = st_q.base_b2;
                IDX_W'(DIW_IDX_BASE_B3):      st_d.rdat = st_q.base_b3;
                IDX_W'(DIW_IDX_SPAN_LO):      st_d.rdat = st_q.span_lo;
                IDX_W'(DIW_IDX_SPAN_HI):      st_d.rdat = {3'b000, st_q.span_hi};
                IDX_W'(DIW_IDX_LEFT_LO):      st_d.rdat = st_q.left_lo;
                IDX_W'(DIW_IDX_LEFT_HI):      st_d.rdat = {3'b000, st_q.left_hi};
                IDX_W'(DIW_IDX_TOP_LO):       st_d.rdat = st_q.top_lo;
                IDX_W'(DIW_IDX_TOP_HI):       st_d.rdat = {3'b000, st_q.top_hi};
                IDX_W'(DIW_IDX_INSET_LO):     st_d.rdat = st_q.inset_select ?
                                                          st_q.inset_lo_2 : st_q.inset_lo_1;
                IDX_W'(DIW_IDX_INSET_SELECT): st_d.rdat = {7'h00, st_q.inset_select};
                IDX_W'(DIW_IDX_STATUS): begin
                    st_d.rdat = 8'h00;
                    st_d.rdat[DIW_ST_LEFT_OVER]  = st_q.left_over;
                    st_d.rdat[DIW_ST_INSET_OVER] = st_q.inset_over;
                    st_d.rdat[DIW_ST_VSYNC]      = vs_link.vsync;
                    st_d.rdat[DIW_ST_SELECT]     = st_q.inset_select;
                end
                // unmapped addresses answer with zero, writes are dropped
                default: st_d.rdat = 8'h00;
            endcase
        end

        if (wr_en) begin
            unique case (idx)
                // RULE_01 six-bit field
                IDX_W'(DIW_IDX_VSYNC_WIDTH):
                    st_d.vsync_width = DIW_VSYNC_W'(wbyte & DIW_MASK_VSYNC);
                // RULE_12 staged low bytes
                IDX_W'(DIW_IDX_BASE_B0): st_d.base_b0 = wbyte & DIW_MASK_QUAD;
                IDX_W'(DIW_IDX_BASE_B1): st_d.base_b1 = wbyte;
                IDX_W'(DIW_IDX_BASE_B2): st_d.base_b2 = wbyte;
                IDX_W'(DIW_IDX_BASE_B3): begin
                    st_d.base_b3 = wbyte;
                    // RULE_02 commit on top byte
                    // RULE_03 low bits forced zero
                    st_d.base = {wbyte, st_q.base_b2, st_q.base_b1,
                                 st_q.base_b0 & DIW_MASK_QUAD};
                end
                IDX_W'(DIW_IDX_SPAN_LO): st_d.span_lo = wbyte & DIW_MASK_QUAD;
                IDX_W'(DIW_IDX_SPAN_HI): begin
                    st_d.span_hi = 5'(wbyte & DIW_MASK_HI5);
                    // RULE_04 span, low bits zero
                    st_d.span = {5'(wbyte & DIW_MASK_HI5), st_q.span_lo[7:2], 2'b00};
                end
                IDX_W'(DIW_IDX_LEFT_LO): st_d.left_lo = wbyte & DIW_MASK_QUAD;
                IDX_W'(DIW_IDX_LEFT_HI): begin
                    st_d.left_hi = 5'(wbyte & DIW_MASK_HI5);
                    // RULE_05 left, low bits zero
                    st_d.left = {5'(wbyte & DIW_MASK_HI5), st_q.left_lo[7:2], 2'b00};
                end
                IDX_W'(DIW_IDX_TOP_LO): st_d.top_lo = wbyte;
                IDX_W'(DIW_IDX_TOP_HI): begin
                    st_d.top_hi = 5'(wbyte & DIW_MASK_HI5);
                    // RULE_07 full 13-bit range
                    st_d.top = {5'(wbyte & DIW_MASK_HI5), st_q.top_lo};
                end
                IDX_W'(DIW_IDX_INSET_LO): begin
                    // RULE_10 selected inset window
                    // RULE_08 low bits zero
                    if (st_q.inset_select) begin
                        st_d.inset_lo_2 = wbyte & DIW_MASK_QUAD;
                    end else begin
                        st_d.inset_lo_1 = wbyte & DIW_MASK_QUAD;
                    end
                end
                IDX_W'(DIW_IDX_INSET_SELECT):
                    st_d.inset_select = wbyte[0];
                default: st_d.vsync_width = st_q.vsync_width;
            endcase
        end

        // the inset top byte lives next door; its write commits our low byte
        if (i_inset_left_hi_wr) begin
            // RULE_10 selected inset window
            // RULE_12 commit staged byte
            if (st_q.inset_select) begin
                st_d.inset_2 = {i_inset_left_hi, st_q.inset_lo_2[7:2], 2'b00};
            end else begin
                st_d.inset_1 = {i_inset_left_hi, st_q.inset_lo_1[7:2], 2'b00};
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign vs_link.width       = st_q.vsync_width;
    assign vs_link.line_tick   = i_line_tick;
    assign vs_link.frame_start = i_frame_start;

    diw_vsync u_vsync (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .vs     (vs_link.pulse)
    );

    assign o_vsync             = vs_link.vsync;
    assign o_wb_ack            = st_q.ack;
    assign o_wb_dat            = {{(DATA_W-8){1'b0}}, st_q.rdat};
    assign o_main_image_base   = st_q.base;
    assign o_main_image_span   = st_q.span;
    assign o_main_view_left    = st_q.left;
    assign o_main_view_top     = st_q.top;
    assign o_inset_view_left_1 = st_q.inset_1;
    assign o_inset_view_left_2 = st_q.inset_2;
    assign o_h_active_width    = st_q.h_width;
endmodule : diw_regs

// file: sim/diw_regs_checker.sv
// port assertions for the image window register group
// assumes bind onto diw_regs; one core clock, synchronous active-low reset
`timescale 1ns/1ns
module diw_regs_checker
    import diw_pkg::*;
#(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 32
) (
    input wire logic                   i_clk,
    input wire logic                   i_rstn,
    input wire logic                   i_wb_cyc,
    input wire logic                   i_wb_stb,
    input wire logic                   i_wb_we,
    input wire logic [ADDR_W-1:0]      i_wb_adr,
    input wire logic [DATA_W-1:0]      o_wb_dat,
    input wire logic                   o_wb_ack,
    input wire logic [7:0]             i_h_active_coarse,
    input wire logic [3:0]             i_h_active_fine,
    input wire logic                   i_frame_start,
    input wire logic                   o_vsync,
    input wire logic [31:0]            o_main_image_base,
    input wire logic [DIW_COORD_W-1:0] o_main_image_span,
    input wire logic [DIW_COORD_W-1:0] o_main_view_left,
    input wire logic [DIW_COORD_W-1:0] o_inset_view_left_1,
    input wire logic [DIW_COORD_W-1:0] o_inset_view_left_2,
    input wire logic [DIW_HW_W-1:0]    o_h_active_width
);
    // reset is synchronous and released by a non-blocking write on an edge; the design
    // still resets on that edge, so checks stay off until one edge after release
    logic run_q;
    always_ff @(posedge i_clk) begin
        run_q <= i_rstn;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn || !run_q);
    logic top_wr;
    assign top_wr = i_wb_cyc && i_wb_stb && i_wb_we
                 && (i_wb_adr[ADDR_W-1:2] == (ADDR_W-2)'(DIW_IDX_BASE_B3));

    property p_ack_take; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
    a_ack_take: assert property (p_ack_take) else $error("ack not one cycle after take");
    property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_rd_hi; o_wb_ack |-> o_wb_dat[DATA_W-1:8] == '0; endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("read data upper bits set");
    property p_base_q; o_main_image_base[1:0] == 2'h0; endproperty
    a_base_q: assert property (p_base_q) else $error("base not word aligned");
    property p_span_q; o_main_image_span[1:0] == 2'h0; endproperty
    a_span_q: assert property (p_span_q) else $error("span low bits set");
    property p_left_q; o_main_view_left[1:0] == 2'h0; endproperty
    a_left_q: assert property (p_left_q) else $error("left low bits set");
    property p_inset_q; (o_inset_view_left_1[1:0] | o_inset_view_left_2[1:0]) == 2'h0; endproperty
    a_inset_q: assert property (p_inset_q) else $error("inset low bits set");
    property p_vs_start; i_frame_start |=> o_vsync; endproperty
    a_vs_start: assert property (p_vs_start) else $error("vsync did not start");
    property p_hw; 1'b1 |=> o_h_active_width == (12'($past(i_h_active_coarse)) + 12'h001)
        * 12'h008 + 12'($past(i_h_active_fine)); endproperty
    a_hw: assert property (p_hw) else $error("display width wrong");
    property p_commit; !$stable(o_main_image_base) |-> $past(top_wr) || $past(top_wr, 2);
    endproperty
    a_commit: assert property (p_commit) else $error("base moved without top write");
endmodule : diw_regs_checker

bind diw_regs diw_regs_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_diw_chk (
    .i_clk, .i_rstn, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack,
    .i_h_active_coarse, .i_h_active_fine, .i_frame_start, .o_vsync, .o_main_image_base,
    .o_main_image_span, .o_main_view_left, .o_inset_view_left_1, .o_inset_view_left_2,
    .o_h_active_width);

// file: sim/diw_host_model.sv
// wishbone classic master standing in for the host processor
// assumes one request pulse at a time, next one only after o_done
`timescale 1ns/1ns
module diw_host_model (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_req,
    input  wire logic        i_we,
    input  wire logic [9:0]  i_adr,
    input  wire logic [3:0]  i_sel,
    input  wire logic [31:0] i_dat,
    input  wire logic        i_ack,
    input  wire logic [31:0] i_wb_dat,
    output logic             o_done,
    output logic [31:0]      o_rdat,
    output logic             o_cyc,
    output logic             o_we,
    output logic [9:0]       o_adr,
    output logic [3:0]       o_sel,
    output logic [31:0]      o_dat
);
    always_ff @(posedge i_clk) begin
        o_done <= 1'b0;
        if (!i_rstn) begin
            o_cyc <= 1'b0;
            o_we  <= 1'b0;
            o_adr <= 10'h000;
            o_sel <= 4'h0;
            o_dat <= 32'h00000000;
        end else if (o_cyc && i_ack) begin
            // released address and data lines show the inverse so stale values cannot pass
            o_cyc  <= 1'b0;
            o_rdat <= i_wb_dat;
            o_done <= 1'b1;
            o_adr  <= ~o_adr;
            o_dat  <= ~o_dat;
        end else if (i_req && !o_cyc) begin
            o_cyc <= 1'b1;
            o_we  <= i_we;
            o_adr <= i_adr;
            o_sel <= i_sel;
            o_dat <= i_dat;
        end
    end
endmodule : diw_host_model

// file: sim/test_display_image_window_regs.sv
// self-checking bench for the image window register group
// assumes the host model drives wishbone, the bench drives timing strobes
`timescale 1ns/1ns
module test_display_image_window_regs;
    import diw_pkg::*;
    logic        i_clk = 1'b0, i_rstn = 1'b0, req = 1'b0, we = 1'b0;
    logic        done, cyc, m_we, ack, hi_wr = 1'b0, tick = 1'b0, fstart = 1'b0, vsync;
    logic [9:0]  adr = 10'h000, m_adr;
    logic [3:0]  sel = 4'h0, m_sel, fine = 4'h3;
    logic [7:0]  coarse = 8'h0A;
    logic [4:0]  hi = 5'h00;
    logic [31:0] wdat = 32'h0, rdat, m_dat, sdat, base;
    logic [12:0] span, left, top, in1, in2;
    logic [11:0] hw;
    int          fails = 0, num_checks = 0, cycles = 0;

    diw_host_model host (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(req), .i_we(we),
        .i_adr(adr), .i_sel(sel), .i_dat(wdat), .i_ack(ack), .i_wb_dat(sdat), .o_done(done),
        .o_rdat(rdat), .o_cyc(cyc), .o_we(m_we), .o_adr(m_adr), .o_sel(m_sel), .o_dat(m_dat));
    diw_regs dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_wb_cyc(cyc), .i_wb_stb(cyc),
        .i_wb_we(m_we), .i_wb_adr(m_adr), .i_wb_sel(m_sel), .i_wb_dat(m_dat),
        .o_wb_dat(sdat), .o_wb_ack(ack), .i_h_active_coarse(coarse), .i_h_active_fine(fine),
        .i_inset_left_hi_wr(hi_wr), .i_inset_left_hi(hi), .i_line_tick(tick),
        .i_frame_start(fstart), .o_vsync(vsync), .o_main_image_base(base),
        .o_main_image_span(span), .o_main_view_left(left), .o_main_view_top(top),
        .o_inset_view_left_1(in1), .o_inset_view_left_2(in2), .o_h_active_width(hw));

    task automatic end_sim();
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       input logic [3:0] s);
        @(posedge i_clk);
        req  <= 1'b1;
        we   <= w;
        adr  <= {idx, 2'h0};
        sel  <= s;
        wdat <= {24'h0, d};
        @(posedge i_clk);
        req <= 1'b0;
        // only the bench timeout ends a wait that never answers
        @(posedge i_clk);
        while (done !== 1'b1) @(posedge i_clk);
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'hF);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] e, input string nm);
        bus(1'b0, idx, 8'h00, 4'hF);
        chk(nm, {24'h0, e}, rdat);
    endtask : rd

    task automatic commit(input logic [4:0] h);
        @(posedge i_clk);
        hi    <= h;
        hi_wr <= 1'b1;
        @(posedge i_clk);
        hi_wr <= 1'b0;
        @(posedge i_clk);
    endtask : commit

    initial forever #10 i_clk = ~i_clk;

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            end_sim();
        end
    end

    initial begin
        repeat (12) @(posedge i_clk);
        i_rstn <= 1'b1;
        for (int i = 'h1F; i <= 'h2A; i++) rd(8'(i), 8'h00, "reset");
        rd(DIW_IDX_STATUS, 8'h00, "status");
        wr(DIW_IDX_BASE_B0, 8'hFF);
        wr(DIW_IDX_BASE_B1, 8'h12);
        wr(DIW_IDX_BASE_B2, 8'h34);
        chk("base staged", 32'h0, base);
        wr(DIW_IDX_BASE_B3, 8'h56);
        chk("base", 32'h563412FC, base);
        rd(DIW_IDX_BASE_B0, 8'hFC, "base_b0");
        bus(1'b1, DIW_IDX_BASE_B3, 8'h77, 4'hE);
        chk("base sel0", 32'h563412FC, base);
        wr(DIW_IDX_SPAN_LO, 8'hFF);
        chk("span staged", 32'h0, 32'(span));
        wr(DIW_IDX_SPAN_HI, 8'hFF);
        chk("span", 32'h1FFC, 32'(span));
        rd(DIW_IDX_SPAN_HI, 8'h1F, "span_hi");
        wr(DIW_IDX_LEFT_LO, 8'h13);
        chk("left staged", 32'h0, 32'(left));
        wr(DIW_IDX_LEFT_HI, 8'hE5);
        chk("left", 32'h0510, 32'(left));
        wr(DIW_IDX_TOP_LO, 8'hFF);
        chk("top staged", 32'h0, 32'(top));
        wr(DIW_IDX_TOP_HI, 8'hFF);
        chk("top", 32'h1FFF, 32'(top));
        wr(8'h30, 8'h5A);
        rd(8'h30, 8'h00, "unmapped");
        wr(DIW_IDX_VSYNC_WIDTH, 8'hC3);
        rd(DIW_IDX_VSYNC_WIDTH, 8'h03, "vsync_width");
        @(posedge i_clk);
        fstart <= 1'b1;
        @(posedge i_clk);
        fstart <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            @(posedge i_clk);
            tick <= 1'b1;
            chk("vsync high", 32'h1, 32'(vsync));
            @(posedge i_clk);
            tick <= 1'b0;
        end
        repeat (2) @(posedge i_clk);
        chk("vsync low", 32'h0, 32'(vsync));
        wr(DIW_IDX_INSET_LO, 8'h0F);
        chk("inset1 staged", 32'h0, 32'(in1));
        commit(5'h02);
        chk("inset1", 32'h020C, 32'(in1));
        wr(DIW_IDX_INSET_SELECT, 8'h01);
        // inset left 0x40 kept below the 91 pixel display width
        wr(DIW_IDX_INSET_LO, 8'h41);
        commit(5'h00);
        chk("inset2", 32'h0040, 32'(in2));
        chk("inset1 kept", 32'h020C, 32'(in1));
        chk("hwidth", 32'd91, 32'(hw));
        rd(DIW_IDX_STATUS, 8'h08, "status sel");
        // left 8188 plus width 91 breaks the host limit on purpose
        wr(DIW_IDX_LEFT_LO, 8'hFC);
        chk("left kept", 32'h0510, 32'(left));
        wr(DIW_IDX_LEFT_HI, 8'h1F);
        rd(DIW_IDX_STATUS, 8'h09, "status over");
        // inset left 0x140 breaks the host limit on purpose
        commit(5'h01);
        rd(DIW_IDX_STATUS, 8'h0B, "status inset over");
        @(posedge i_clk);
        coarse <= 8'hFF;
        fine   <= 4'hF;
        repeat (3) @(posedge i_clk);
        chk("hwidth max", 32'd2063, 32'(hw));
        // reset again mid-run: active settings must clear
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        chk("base reset", 32'h0, base);
        chk("left reset", 32'h0, 32'(left));
        rd(DIW_IDX_LEFT_HI, 8'h00, "left_hi reset");
        end_sim();
    end
endmodule : test_display_image_window_regs
